// ### verilog/rgsw_top.sv
// run guard at power-up and sleep/wake gating of the drive run command
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module rgsw_top
    import rgsw_pkg::*;
#(
    parameter int TICK_CYCLES = RGSW_TICK_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    input  wire logic        run_term_in,
    input  wire logic [15:0] set_freq_in,
    input  wire logic [15:0] run_freq_in,
    output logic             run_out,
    output logic             coast_out,
    output logic             protect_out
);
    // elaboration check: the tenth-second divider is only 28 bits wide
    if (TICK_CYCLES < 1 || TICK_CYCLES > 32'h0FFF_FFFF) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    rgsw_state_t state_r;
    rgsw_state_t state_nxt;
    logic [4:0]  ctrl_r;
    logic [15:0] wake_delay_r;
    logic [15:0] limit_r;
    logic [11:0] init_cnt_r;
    logic        term_seen_r;
    logic [27:0] div_r;
    logic [15:0] wake_cnt_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    logic        guard;
    logic [1:0]  lf_action;
    logic        term_src;
    logic        run_cmd;
    logic        init_done;
    logic        sleep_mode;
    logic        set_low;
    logic        run_low;
    logic        set_high;
    logic        tick;
    logic        wake_ok;
    logic        acc;
    logic        wr_en;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == RGSW_CTRL_OFS) || (a == RGSW_WAKE_OFS) ||
                 (a == RGSW_LIMIT_OFS) || (a == RGSW_STATUS_OFS);
    endfunction

    // decoded controls
    assign guard      = ctrl_r[RGSW_GUARD_BIT];
    assign lf_action  = ctrl_r[RGSW_ACT_LSB +: 2];
    assign term_src   = ctrl_r[RGSW_TERM_BIT];
    assign run_cmd    = term_src ? run_term_in : ctrl_r[RGSW_SWRUN_BIT];
    assign init_done  = (init_cnt_r == RGSW_INIT_LAST);
    assign sleep_mode = (lf_action == RGSW_ACT_SLEEP);
    assign set_low    = (set_freq_in < limit_r);
    assign run_low    = (run_freq_in < limit_r);
    assign set_high   = (set_freq_in > limit_r);
    assign tick       = (div_r == 28'(TICK_CYCLES - 1));
    assign wake_ok    = set_high && (wake_cnt_r >= wake_delay_r);

    // apb: one wait state, so pready and data come from flops
    assign acc   = psel_in && penable_in;
    assign wr_en = acc && pready_r && pwrite_in && mapped(paddr_in);

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !mapped(paddr_in);
            prdata_r  <= 32'h0000_0000;
            if (acc && !pready_r && !pwrite_in) begin
                unique case (paddr_in)
                    RGSW_CTRL_OFS:   prdata_r <= {27'h0, ctrl_r};
                    RGSW_WAKE_OFS:   prdata_r <= {16'h0, wake_delay_r};
                    RGSW_LIMIT_OFS:  prdata_r <= {16'h0, limit_r};
                    RGSW_STATUS_OFS: prdata_r <= {26'h0, term_seen_r,
                                                  3'(state_r),
                                                  coast_out, run_out};
                    default:         prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // register writes, only at the completing edge
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r       <= RGSW_CTRL_RST;
            wake_delay_r <= RGSW_WAKE_RST;
            limit_r      <= RGSW_LIMIT_RST;
        end else if (wr_en) begin
            unique case (paddr_in)
                RGSW_CTRL_OFS:  ctrl_r  <= pwdata_in[4:0];
                RGSW_WAKE_OFS:  wake_delay_r <=
                    (pwdata_in[15:0] > RGSW_WAKE_MAX) ? RGSW_WAKE_MAX
                                                      : pwdata_in[15:0];
                RGSW_LIMIT_OFS: limit_r <= pwdata_in[15:0];
                default:        ;
            endcase
        end
    end

    // power-up init counter and terminal capture
    // sample run terminal
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            init_cnt_r  <= 12'h000;
            term_seen_r <= 1'b0;
        end else if (state_r == RGSW_INIT) begin
            if (!init_done)
                init_cnt_r <= init_cnt_r + 12'h001;
            if (term_src && run_term_in)
                term_seen_r <= 1'b1;
        end
    end

    // tenth-second divider, runs only while waiting to wake so the
    // delay starts aligned with the moment the setpoint rose
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            div_r <= 28'h0;
        else if (state_r != RGSW_SLEEP || !set_high || tick)
            div_r <= 28'h0;
        else
            div_r <= div_r + 28'h1;
    end

    // wake delay count in tenths
    // dip restarts count
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            wake_cnt_r <= 16'h0000;
        else if (state_r != RGSW_SLEEP || !set_high)
            wake_cnt_r <= 16'h0000;
        else if (tick && wake_cnt_r != 16'hFFFF)
            wake_cnt_r <= wake_cnt_r + 16'h0001;
    end

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RGSW_INIT: begin
                if (init_done) begin
                    if (term_seen_r && guard)
                        state_nxt = RGSW_RUN;
                    else if (term_seen_r)
                        state_nxt = RGSW_PROTECT;
                    else
                        state_nxt = RGSW_STOPPED;
                end
            end
            RGSW_PROTECT: begin
                if (!run_term_in || !term_src)
                    state_nxt = RGSW_STOPPED;
            end
            RGSW_STOPPED: begin
                if (run_cmd)
                    state_nxt = RGSW_RUN;
            end
            RGSW_RUN: begin
                if (!run_cmd)
                    state_nxt = RGSW_STOPPED;
                else if (sleep_mode && (set_low || run_low))
                    state_nxt = RGSW_SLEEP;
            end
            RGSW_SLEEP: begin
                if (!run_cmd)
                    state_nxt = RGSW_STOPPED;
                else if (!sleep_mode || wake_ok)
                    state_nxt = RGSW_RUN;
            end
            default: state_nxt = RGSW_STOPPED;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            state_r <= RGSW_INIT;
        else
            state_r <= state_nxt;
    end

    // drive outputs follow the state register exactly
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_out     <= 1'b0;
            coast_out   <= 1'b0;
            protect_out <= 1'b0;
        end else begin
            run_out     <= (state_nxt == RGSW_RUN);
            coast_out   <= (state_nxt == RGSW_SLEEP);
            protect_out <= (state_nxt == RGSW_PROTECT);
        end
    end

    assign pready_out  = pready_r;
    assign prdata_out  = prdata_r;
    assign pslverr_out = pslverr_r;

    a_init_no_run: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_INIT |-> !run_out)
        else $error("drive ran during init");

    a_guard_protect: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_INIT && init_done && term_seen_r && !guard
        |=> state_r == RGSW_PROTECT && protect_out && !run_out)
        else $error("guard 0 did not protect");

    a_protect_release: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_PROTECT |=> state_r != RGSW_RUN)
        else $error("protection left without release");

    a_auto_start: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_INIT && init_done && term_seen_r && guard
        |=> run_out)
        else $error("guard 1 did not auto start");

    a_sleep_coast: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_RUN && run_cmd && sleep_mode && set_low
        |=> coast_out && !run_out)
        else $error("no coast on low setpoint");

    a_run_freq_sleep: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_RUN && run_cmd && sleep_mode && run_low
        |=> state_r == RGSW_SLEEP)
        else $error("no sleep on low running freq");

    a_wake_early: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_SLEEP && sleep_mode &&
        (wake_cnt_r < wake_delay_r || !set_high)
        |=> !run_out)
        else $error("woke before delay");

    a_delay_range: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        wake_delay_r <= RGSW_WAKE_MAX)
        else $error("wake delay above ceiling");

    a_wake_restart: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        state_r == RGSW_SLEEP && !set_high
        |=> wake_cnt_r == 16'h0000 && div_r == 28'h0)
        else $error("wake count not restarted");
endmodule

// ### verilog/rgsw_pkg.sv
// constants, register map and state type for the run guard / sleep block
package rgsw_pkg;
    // register byte offsets
    localparam logic [7:0]  RGSW_CTRL_OFS     = 8'h00;
    localparam logic [7:0]  RGSW_WAKE_OFS     = 8'h04;
    localparam logic [7:0]  RGSW_LIMIT_OFS    = 8'h08;
    localparam logic [7:0]  RGSW_STATUS_OFS   = 8'h0C;
    // control field positions
    localparam int          RGSW_GUARD_BIT    = 0;
    localparam int          RGSW_ACT_LSB      = 1;
    localparam int          RGSW_TERM_BIT     = 3;
    localparam int          RGSW_SWRUN_BIT    = 4;
    // reset values
    localparam logic [4:0]  RGSW_CTRL_RST     = 5'h08;
    localparam logic [15:0] RGSW_WAKE_RST     = 16'h0000;
    localparam logic [15:0] RGSW_LIMIT_RST    = 16'h0000;
    // low-frequency action code for sleep
    localparam logic [1:0]  RGSW_ACT_SLEEP    = 2'h2;
    // wake delay in tenths of a second, 3600.0 s ceiling
    localparam logic [15:0] RGSW_WAKE_MAX     = 16'h8CA0;
    // timing
    localparam int          RGSW_CLK_NS       = 25;
    localparam int          RGSW_TENTH_NS     = 100_000_000;
    localparam int          RGSW_TICK_CYCLES  = RGSW_TENTH_NS / RGSW_CLK_NS;
    localparam int          RGSW_INIT_NS      = 100_000;
    localparam int          RGSW_INIT_CYCLES  = RGSW_INIT_NS / RGSW_CLK_NS;
    localparam logic [11:0] RGSW_INIT_LAST    = 12'(RGSW_INIT_CYCLES - 1);

    typedef enum logic [2:0] {
        RGSW_INIT,
        RGSW_PROTECT,
        RGSW_STOPPED,
        RGSW_RUN,
        RGSW_SLEEP
    } rgsw_state_t;
endpackage

// ### bench/rgsw_term_model.sv
// partner model: outside controller that drives the run terminal
`timescale 1ns/1ps
module rgsw_term_model (
    input  wire logic clk_in,
    input  wire logic want_in,
    output logic      term_out
);
    initial term_out = 1'b0;
    // release and reassert
    // terminal follows the controller one edge late, like a relay contact
    always @(posedge clk_in) begin
        term_out <= want_in;
    end
endmodule

// ### bench/tb_run_guard_and_sleep_wake.sv
// self-checking bench for the run guard and sleep/wake block
`timescale 1ns/1ps
module tb_run_guard_and_sleep_wake;
    import rgsw_pkg::*;
    localparam int TICK = 4;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        want;
    logic        term;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [15:0] set_f;
    logic [15:0] run_f;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        run;
    logic        coast;
    logic        protect;
    logic [31:0] rd;
    logic        err;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    rgsw_top #(.TICK_CYCLES(TICK)) dut (
        .sys_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
        .pslverr_out(pslverr), .run_term_in(term), .set_freq_in(set_f),
        .run_freq_in(run_f), .run_out(run), .coast_out(coast),
        .protect_out(protect)
    );
    rgsw_term_model u_term (.clk_in(clk), .want_in(want), .term_out(term));

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard: two init phases plus margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer; request held until pready seen at an edge
    // no local wait limit: only the global hang guard ends a wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
    endtask

    task automatic test_guard_off();
        want <= 1'b1;
        do_reset();
        cyc(4010);
        chk(protect, 1);
        chk(run, 0);
        want <= 1'b0;
        cyc(4);
        chk(run, 0);
        want <= 1'b1;
        cyc(4);
        chk(run, 1);
        $display("test guard_off done");
    endtask

    task automatic test_regs();
        apb(1'b0, RGSW_WAKE_OFS, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, RGSW_WAKE_OFS, 32'h0000_FFFF);
        apb(1'b0, RGSW_WAKE_OFS, 32'h0);
        chk(rd, 32'h0000_8CA0);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1);
        $display("test regs done");
    endtask

    task automatic test_sleep();
        apb(1'b1, RGSW_LIMIT_OFS, 32'h0000_0064);
        apb(1'b1, RGSW_WAKE_OFS, 32'h0000_0003);
        set_f <= 16'h0032;
        cyc(4);
        chk(run, 1);
        apb(1'b1, RGSW_CTRL_OFS, 32'h0000_000C);
        cyc(3);
        chk(coast, 1);
        chk(run, 0);
        set_f <= 16'h00C8;
        cyc(6);
        set_f <= 16'h0032;
        cyc(2);
        set_f <= 16'h00C8;
        cyc(8);
        chk(coast, 1);
        cyc(10);
        chk(run, 1);
        run_f <= 16'h0032;
        cyc(3);
        chk(coast, 1);
        run_f <= 16'h00C8;
        $display("test sleep done");
    endtask

    task automatic test_guard_on();
        want <= 1'b1;
        do_reset();
        cyc(5);
        apb(1'b1, RGSW_CTRL_OFS, 32'h0000_0009);
        cyc(4010);
        chk(run, 1);
        chk(protect, 0);
        // status: terminal seen, state code 3, coast 0, run 1
        apb(1'b0, RGSW_STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_002D);
        // software source: the terminal no longer counts
        apb(1'b1, RGSW_CTRL_OFS, 32'h0000_0011);
        want <= 1'b0;
        cyc(4);
        chk(run, 1);
        apb(1'b1, RGSW_CTRL_OFS, 32'h0000_0001);
        cyc(2);
        chk(run, 0);
        $display("test guard_on done");
    endtask

    // main sequence
    initial begin
        rstn    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        want    = 1'b0;
        set_f   = 16'h00C8;
        run_f   = 16'h00C8;
        test_guard_off();
        test_regs();
        test_sleep();
        test_guard_on();
        print_verdict();
    end
endmodule
